// File: design/bscac_pkg.sv
/*
  Shared constants for the clock/analog boundary-scan segment: chain layout,
  safe values for unused cells, link timing and the controller's APB map.
  Assumes nothing of its surroundings.
*/
package bscac_pkg;

  // ----------------------------------------------------------------
  // Chain layout
  // ----------------------------------------------------------------
  localparam int NCTRL = 25;
  localparam int NCLK = 4;
  localparam int NOBS = 5;
  localparam int CHAIN_LEN = NCTRL + NOBS;
  localparam int UPD_W = NCTRL + 1;

  // Controlled cells, chain bits 0..24
  localparam int CTL_EXT_EN = 0;
  localparam int CTL_XTAL_EN = 1;
  localparam int CTL_LF_EN = 2;
  localparam int CTL_AUX_EN = 3;
  localparam int CTL_CMP_IDLE = 4;
  localparam int CTL_CMP_MUX = 5;
  localparam int CTL_CMP_BG = 6;
  localparam int CTL_GAIN_PATH = 7;
  localparam int CTL_CONV_BG = 8;
  localparam int CTL_CONV_PWR = 9;
  localparam int CTL_GAIN_PWR = 10;
  localparam int CTL_DAC_LSB = 11;
  localparam int DAC_W = 10;
  localparam int CTL_EXT_CH = 21;
  localparam int CTL_G10 = 22;
  localparam int CTL_G20 = 23;
  localparam int CTL_SC_CLK = 24;

  // Observed cells: chain bits 25..28 clock lines, 29 comparator result
  localparam int OBS_CLK_LSB = NCTRL;
  localparam int OBS_RESULT = NCTRL + NCLK;
  localparam int UPD_RESULT = NCTRL;

  // Safe values: comparator idle, DAC bit 9, external channel bypass set
  localparam logic [NCTRL-1:0] CTRL_SAFE = 25'h0300010;
  // Recommended stimulus: safe values plus the external main clock enabled
  localparam logic [NCTRL-1:0] TX_RESET = 25'h0300011;
  // Scanned clock line when its option is unused: main 0, others 1
  localparam logic [NCLK-1:0] CLK_UNUSED = 4'he;

  // ----------------------------------------------------------------
  // Link timing and controller registers
  // ----------------------------------------------------------------
  localparam int TCK_HALF_CYCLES = 8;
  localparam int SYNC_W = 11;

  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_STATUS = 12'h004;
  localparam logic [11:0] ADDR_TX = 12'h008;
  localparam logic [11:0] ADDR_RX = 12'h00c;
  localparam int CTRL_START = 0;
  localparam int CTRL_EXTEST = 1;
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_CONFLICT = 2;

  typedef enum logic [4:0] {
    BSCAC_IDLE = 5'b00001,
    BSCAC_CAP = 5'b00010,
    BSCAC_SHIFT = 5'b00100,
    BSCAC_UPD = 5'b01000,
    BSCAC_FIN = 5'b10000
  } bscac_state_t;

  // More than one clock-source enable set at once
  function automatic logic bscac_multi_clk(input logic [NCLK-1:0] en);
    logic [2:0] cnt;
    cnt = 3'h0;
    for (int i = 0; i < NCLK; i++) begin
      cnt = cnt + {2'h0, en[i]};
    end
    return cnt > 3'h1;
  endfunction : bscac_multi_clk

endpackage : bscac_pkg

// File: design/bscac_link_if.sv
/*
  Scan link between the external test controller and the scan segment.
  Assumes the controller drives the test clock and the state levels, which
  change only while the test clock is low.
*/
`timescale 1ns/1ps
`default_nettype none

interface bscac_link_if;
  logic tck;
  logic tdi;
  logic tdo;
  logic captureDr;
  logic shiftDr;
  logic updateDr;
  logic extestMode;

  modport dev (
    input tck,
    input tdi,
    input captureDr,
    input shiftDr,
    input updateDr,
    input extestMode,
    output tdo
  );

  modport ctl (
    output tck,
    output tdi,
    output captureDr,
    output shiftDr,
    output updateDr,
    output extestMode,
    input tdo
  );
endinterface : bscac_link_if

`default_nettype wire

// File: design/bscac_scan_cells.sv
/*
  Boundary-scan segment for the oscillator/clock pins, the analog comparator
  and the ADC converter interface (device end of the scan link).
  Assumes the link arrives asynchronously to ref_clk and is oversampled;
  the test clock must stay below a quarter of ref_clk.
*/
// Overview of operation
// - Pinned oscillator enables get general cells
// - Clock outputs feed observe-only cells
// - Timer-two oscillator scanned like main clock
// - Internal RC oscillator stays out of chain
// - Unused clock line reads 0 main, else 1
// - Controller enables one clock source at most
// - Clock enables stay in chain through sleep
// - Controller prefers observing the external clock
// - Comparator signals each get general cells
// - Mux-select feeds comparator from ADC mux
// - Comparator not needed for connectivity tests
// - Ten converter cells; unused value 0x200
// - External-channel cell routes channels 0-3 around gain
// - Power-on cells power circuit only when set
// - Gain path and gain cells, unused zero
// - Switched-capacitor clock cell, unused zero
// - External test applies chain at update
`timescale 1ns/1ps
`default_nettype none

module bscac_scan_cells
  import bscac_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst_n,
  bscac_link_if.dev link,
  input wire logic [NCTRL-1:0] funcCtrl,
  input wire logic extMainClockLine,
  input wire logic crystalOscClock,
  input wire logic lowfreqCrystalClock,
  input wire logic auxTimerOscClock,
  input wire logic comparatorRaw,
  output logic comparatorResult,
  output logic extMainClockEnable,
  output logic crystalOscEnable,
  output logic lowfreqCrystalEnable,
  output logic auxTimerOscEnable,
  output logic comparatorIdleCtrl,
  output logic comparatorMuxSelect,
  output logic comparatorBandgapEnable,
  output logic gainPathEnable,
  output logic converterBandgapEnable,
  output logic converterPowerOn,
  output logic gainStagePowerOn,
  output logic [DAC_W-1:0] converterValue,
  output logic externalChannelBypass,
  output logic gainTenEnable,
  output logic gainTwentyEnable,
  output logic switchCapClock
);

  // ----------------------------------------------------------------
  // Input synchronisers
  // ----------------------------------------------------------------
  // Link levels, clock lines and comparator all pass the same three stages,
  // so data and test clock keep their relative timing.
  logic [SYNC_W-1:0] rawIn;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  logic [SYNC_W-1:0] sync3_reg;
  logic [SYNC_W-1:0] filt_reg;
  logic [SYNC_W-1:0] filt_next;

  assign rawIn = {comparatorRaw, auxTimerOscClock, lowfreqCrystalClock,
                  crystalOscClock, extMainClockLine, link.extestMode,
                  link.updateDr, link.shiftDr, link.captureDr, link.tdi,
                  link.tck};
  assign filt_next = (sync2_reg & sync3_reg) | (filt_reg & (sync2_reg ^ sync3_reg));

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
      filt_reg <= '0;
    end else begin
      sync1_reg <= rawIn;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
      filt_reg <= filt_next;
    end
  end

  wire tckS = filt_reg[0];
  wire tdiS = filt_reg[1];
  wire captureS = filt_reg[2];
  wire shiftS = filt_reg[3];
  wire updateS = filt_reg[4];
  wire extestS = filt_reg[5];
  wire [NCLK-1:0] clockS = filt_reg[9:6];
  wire comparatorS = filt_reg[10];

  logic tckPrev_reg;
  wire tckRise = tckS & ~tckPrev_reg;
  wire tckFall = ~tckS & tckPrev_reg;

  // ----------------------------------------------------------------
  // Capture vector
  // ----------------------------------------------------------------
  logic [NCTRL-1:0] applied_reg;
  logic comparatorResult_reg;
  logic [NCLK-1:0] clockEnables;
  logic [NCLK-1:0] clockObserved;
  logic [CHAIN_LEN-1:0] captureVec;

  // Only pinned clocks
  // Four clock options exist in the chain; the RC oscillator has no pin.
  assign clockEnables = applied_reg[CTL_AUX_EN:CTL_EXT_EN];
  assign clockObserved = (clockS & clockEnables) | (CLK_UNUSED & ~clockEnables);
  assign captureVec = {comparatorS, clockObserved, applied_reg};

  // ----------------------------------------------------------------
  // Shift and update stages
  // ----------------------------------------------------------------
  logic [CHAIN_LEN-1:0] shift_reg;
  logic [UPD_W-1:0] update_reg;
  logic updPending_reg;
  logic tdo_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tckPrev_reg <= 1'b0;
    end else begin
      tckPrev_reg <= tckS;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= '0;
      updPending_reg <= 1'b0;
    end else if (tckRise) begin
      if (captureS) begin
        shift_reg <= captureVec;
      end else if (shiftS) begin
        shift_reg <= {tdiS, shift_reg[CHAIN_LEN-1:1]};
      end
      updPending_reg <= updateS;
    end else if (tckFall) begin
      updPending_reg <= 1'b0;
    end
  end

  // Update latches on the falling test clock that closes the update state,
  // so a shift never disturbs the applied values mid-frame.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tdo_reg <= 1'b0;
      update_reg <= {1'b0, CTRL_SAFE};
    end else if (tckFall) begin
      tdo_reg <= shift_reg[0];
      if (updPending_reg) begin
        update_reg <= {shift_reg[OBS_RESULT], shift_reg[NCTRL-1:0]};
      end
    end
  end

  assign link.tdo = tdo_reg;

  // ----------------------------------------------------------------
  // Applied values
  // ----------------------------------------------------------------
  // Apply only in external test
  // Scan enables override sleep gating
  // In sample/preload the update stage is loaded but never reaches the pins.
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      applied_reg <= CTRL_SAFE;
      comparatorResult_reg <= 1'b0;
    end else begin
      applied_reg <= extestS ? update_reg[NCTRL-1:0] : funcCtrl;
      comparatorResult_reg <= extestS ? update_reg[UPD_RESULT] : comparatorS;
    end
  end

  assign extMainClockEnable = applied_reg[CTL_EXT_EN];
  assign crystalOscEnable = applied_reg[CTL_XTAL_EN];
  assign lowfreqCrystalEnable = applied_reg[CTL_LF_EN];
  assign auxTimerOscEnable = applied_reg[CTL_AUX_EN];
  assign comparatorIdleCtrl = applied_reg[CTL_CMP_IDLE];
  assign comparatorBandgapEnable = applied_reg[CTL_CMP_BG];
  assign comparatorResult = comparatorResult_reg;
  assign comparatorMuxSelect = applied_reg[CTL_CMP_MUX];
  assign gainPathEnable = applied_reg[CTL_GAIN_PATH];
  assign gainTenEnable = applied_reg[CTL_G10];
  assign gainTwentyEnable = applied_reg[CTL_G20];
  assign converterBandgapEnable = applied_reg[CTL_CONV_BG];
  assign converterPowerOn = applied_reg[CTL_CONV_PWR];
  assign gainStagePowerOn = applied_reg[CTL_GAIN_PWR];
  assign converterValue = applied_reg[CTL_DAC_LSB +: DAC_W];
  assign externalChannelBypass = applied_reg[CTL_EXT_CH];
  assign switchCapClock = applied_reg[CTL_SC_CLK];

endmodule : bscac_scan_cells

`default_nettype wire

// File: design/bscac_scan_master.sv
/*
  Test controller end of the scan link: APB registers, test clock divider
  and one capture/shift/update frame per start command written while idle and not refused for two or more clock enables in TX.
  Assumes an APB master on ref_clk; the scan segment oversamples the link.
*/
// Design decisions made here: the address map and the APB register port.
`timescale 1ns/1ps
`default_nettype none

module bscac_scan_master
  import bscac_pkg::*;
#(
  parameter int HALF_CYCLES = TCK_HALF_CYCLES
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  bscac_link_if.ctl link
);

  // ----------------------------------------------------------------
  // APB decode
  // ----------------------------------------------------------------
  wire hitCtrl = paddr == ADDR_CTRL;
  wire hitStatus = paddr == ADDR_STATUS;
  wire hitTx = paddr == ADDR_TX;
  wire hitRx = paddr == ADDR_RX;
  wire hitAny = hitCtrl | hitStatus | hitTx | hitRx;
  wire access = psel & penable;
  wire wrEn = access & pwrite & hitAny;

  logic extest_reg;
  logic busy_reg;
  logic done_reg;
  logic conflict_reg;
  logic [CHAIN_LEN-1:0] tx_reg;
  logic [CHAIN_LEN-1:0] txShift_reg;
  logic [CHAIN_LEN-1:0] rx_reg;
  logic [31:0] prdata_reg;
  logic [31:0] readMux;

  assign readMux = hitCtrl ? {30'h0, extest_reg, 1'b0} :
                   hitStatus ? {29'h0, conflict_reg, done_reg, busy_reg} :
                   hitTx ? {2'h0, tx_reg} :
                   hitRx ? {2'h0, rx_reg} : 32'h0;
  assign pready = 1'b1;
  assign pslverr = access & ~hitAny;
  assign prdata = prdata_reg;

  wire multiClk = bscac_multi_clk(tx_reg[CTL_AUX_EN:CTL_EXT_EN]);
  wire startReq = wrEn & hitCtrl & pwdata[CTRL_START] & ~busy_reg;
  wire startOk = startReq & ~multiClk;
  wire clrDone = wrEn & hitStatus & pwdata[ST_DONE];
  wire clrConflict = wrEn & hitStatus & pwdata[ST_CONFLICT];

  // ----------------------------------------------------------------
  // Test clock divider
  // ----------------------------------------------------------------
  logic [7:0] div_reg;
  logic tck_reg;
  wire halfDone = div_reg == 8'(HALF_CYCLES - 1);
  wire tickRise = busy_reg & halfDone & ~tck_reg;
  wire tickFall = busy_reg & halfDone & tck_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      div_reg <= 8'h0;
      tck_reg <= 1'b0;
    end else if (!busy_reg || halfDone) begin
      div_reg <= 8'h0;
      tck_reg <= busy_reg & ~tck_reg;
    end else begin
      div_reg <= div_reg + 8'h1;
    end
  end

  // ----------------------------------------------------------------
  // Returning data synchroniser
  // ----------------------------------------------------------------
  logic [2:0] tdoSync_reg;
  logic tdoS_reg;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tdoSync_reg <= 3'h0;
      tdoS_reg <= 1'b0;
    end else begin
      tdoSync_reg <= {tdoSync_reg[1:0], link.tdo};
      if (tdoSync_reg[1] == tdoSync_reg[2]) begin
        tdoS_reg <= tdoSync_reg[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Frame sequencer
  // ----------------------------------------------------------------
  bscac_state_t state_reg;
  logic [7:0] bitCnt_reg;
  logic capOut_reg;
  logic shiftOut_reg;
  logic updOut_reg;
  logic tdi_reg;
  wire allShifted = bitCnt_reg == 8'(CHAIN_LEN);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= BSCAC_IDLE;
      bitCnt_reg <= 8'h0;
      busy_reg <= 1'b0;
      txShift_reg <= '0;
      rx_reg <= '0;
      capOut_reg <= 1'b0;
      shiftOut_reg <= 1'b0;
      updOut_reg <= 1'b0;
      tdi_reg <= 1'b0;
    end else begin
      case (state_reg)
        BSCAC_IDLE: begin
          if (startOk) begin
            state_reg <= BSCAC_CAP;
            busy_reg <= 1'b1;
            bitCnt_reg <= 8'h0;
            txShift_reg <= tx_reg;
            capOut_reg <= 1'b1;
            tdi_reg <= tx_reg[0];
          end
        end
        BSCAC_CAP: begin
          if (tickFall) begin
            state_reg <= BSCAC_SHIFT;
            capOut_reg <= 1'b0;
            shiftOut_reg <= 1'b1;
          end
        end
        BSCAC_SHIFT: begin
          if (tickRise) begin
            txShift_reg <= {1'b0, txShift_reg[CHAIN_LEN-1:1]};
            bitCnt_reg <= bitCnt_reg + 8'h1;
          end else if (tickFall) begin
            // Returning bit is taken a half period late: the round trip
            // through both link filters is too long to catch it at the rise.
            rx_reg <= {tdoS_reg, rx_reg[CHAIN_LEN-1:1]};
            tdi_reg <= txShift_reg[0];
            if (allShifted) begin
              shiftOut_reg <= 1'b0;
              updOut_reg <= 1'b1;
              state_reg <= BSCAC_UPD;
            end
          end
        end
        BSCAC_UPD: begin
          if (tickRise) begin
            state_reg <= BSCAC_FIN;
          end
        end
        BSCAC_FIN: begin
          if (tickFall) begin
            updOut_reg <= 1'b0;
            busy_reg <= 1'b0;
            state_reg <= BSCAC_IDLE;
          end
        end
        default: begin
          state_reg <= BSCAC_IDLE;
          busy_reg <= 1'b0;
        end
      endcase
    end
  end

  wire frameEnd = (state_reg == BSCAC_FIN) & tickFall;

  // ----------------------------------------------------------------
  // Software registers
  // ----------------------------------------------------------------
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      extest_reg <= 1'b0;
      tx_reg <= {{NOBS{1'b0}}, TX_RESET};
      done_reg <= 1'b0;
      conflict_reg <= 1'b0;
      prdata_reg <= 32'h0;
    end else begin
      if (psel && !penable) begin
        prdata_reg <= pwrite ? 32'h0 : readMux;
      end
      // Mode is frozen while a frame runs so the device never switches mid-frame
      if (wrEn && hitCtrl && !busy_reg) begin
        extest_reg <= pwdata[CTRL_EXTEST];
      end
      if (wrEn && hitTx && !busy_reg) begin
        tx_reg <= pwdata[CHAIN_LEN-1:0];
      end
      // Hardware set wins over a software clear in the same cycle
      done_reg <= frameEnd | (done_reg & ~clrDone);
      conflict_reg <= (startReq & multiClk) | (conflict_reg & ~clrConflict);
    end
  end

  assign link.tck = tck_reg;
  assign link.tdi = tdi_reg;
  assign link.captureDr = capOut_reg;
  assign link.shiftDr = shiftOut_reg;
  assign link.updateDr = updOut_reg;
  assign link.extestMode = extest_reg;

endmodule : bscac_scan_master

`default_nettype wire

// File: verif/bscac_link_checker.sv
/*
  Concurrent checks on the scan link between controller and segment.
  Assumes the link signals as plain inputs, sampled on ref_clk.
*/
`timescale 1ns/1ps
`default_nettype none
module bscac_link_checker #(
  parameter int HALF_CYCLES = 8
)(
  input wire logic ref_clk,
  input wire logic rst_n,
  input wire logic tck,
  input wire logic tdi,
  input wire logic tdo,
  input wire logic captureDr,
  input wire logic shiftDr,
  input wire logic updateDr,
  input wire logic extestMode
);
  localparam int CAP_MIN = 2 * HALF_CYCLES - 1;
  localparam int CAP_MAX = 2 * HALF_CYCLES + 1;
  logic tckQ_reg;
  logic [5:0] riseCnt_reg;
  logic [5:0] riseCnt_next;
  wire logic inFrame = captureDr | shiftDr | updateDr;
  assign riseCnt_next = shiftDr ? riseCnt_reg + {5'h0, tck & ~tckQ_reg} : 6'h0;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tckQ_reg <= 1'b0;
      riseCnt_reg <= 6'h0;
    end else begin
      tckQ_reg <= tck;
      riseCnt_reg <= riseCnt_next;
    end
  end
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------------------------------
  // Frame steps
  // ----------------------------------------------------------------
  sequence s_cap_end;
    ##[CAP_MIN:CAP_MAX] ($fell(captureDr) && shiftDr);
  endsequence
  sequence s_upd_end;
    updateDr ##[CAP_MIN:CAP_MAX] $fell(updateDr);
  endsequence
  // Repetition count fixed at the default half period of 8
  sequence s_tck_high;
    tck [*8] ##1 !tck;
  endsequence
  a_one_state: assert property ($onehot0({captureDr, shiftDr, updateDr}))
    else $error("more than one scan state active");
  a_state_tck_low: assert property ($changed({captureDr, shiftDr, updateDr}) |-> !tck)
    else $error("scan state changed while tck high");
  a_capture_then_shift: assert property ($rose(captureDr) |-> s_cap_end)
    else $error("capture not one tck cycle before shift");
  a_shift_count: assert property ($fell(shiftDr) |-> riseCnt_reg == 6'h1e)
    else $error("shift did not last thirty tck rises");
  a_update_after_shift: assert property ($fell(shiftDr) |-> s_upd_end)
    else $error("update cycle missing after shift");
  a_tck_high_time: assert property ($rose(tck) |-> s_tck_high)
    else $error("tck high time wrong");
  a_tck_idle_low: assert property (!inFrame |-> !tck)
    else $error("tck running outside a frame");
  a_serial_tck_low: assert property ($changed({tdi, tdo}) |-> !tck)
    else $error("serial data changed while tck high");
  a_mode_outside_frame: assert property ($changed(extestMode) |-> !$past(inFrame))
    else $error("test mode changed inside a frame");
endmodule : bscac_link_checker
`default_nettype wire

// File: verif/tb_top.sv
/*
  Self-checking bench: scan controller and scan segment joined by the link.
  Assumes ref_clk at 125 MHz and the controller register map of the package.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top
  import bscac_pkg::*;
;
  typedef struct packed {logic [29:0] tx; logic [3:0] lines; logic raw;} bscac_row_t;
  logic ref_clk, rst_n, psel, penable, pwrite, pready, pslverr, raw, cres, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [NCTRL-1:0] funcCtrl;
  logic [NCLK-1:0] lines, expObs;
  logic [CHAIN_LEN-1:0] tdiMon, tdoMon;
  wire logic [NCTRL-1:0] applied;
  int miscompares, checks;
  bscac_row_t rows [5] = '{{30'h0300011, 4'h0, 1'b1}, {30'h21fffff2, 4'hd, 1'b0},
    {30'h0aaaaa4, 4'hb, 1'b1}, {30'h21555558, 4'h7, 1'b0}, {30'h0, 4'hf, 1'b1}};
  bscac_link_if link();
  bscac_scan_master #(.HALF_CYCLES(8)) i_bscac_scan_master (.ref_clk(ref_clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link));
  bscac_scan_cells i_bscac_scan_cells (.ref_clk(ref_clk), .rst_n(rst_n), .link(link),
    .funcCtrl(funcCtrl), .extMainClockLine(lines[0]), .crystalOscClock(lines[1]),
    .lowfreqCrystalClock(lines[2]), .auxTimerOscClock(lines[3]), .comparatorRaw(raw),
    .comparatorResult(cres), .extMainClockEnable(applied[0]), .crystalOscEnable(applied[1]),
    .lowfreqCrystalEnable(applied[2]), .auxTimerOscEnable(applied[3]),
    .comparatorIdleCtrl(applied[4]), .comparatorMuxSelect(applied[5]),
    .comparatorBandgapEnable(applied[6]), .gainPathEnable(applied[7]),
    .converterBandgapEnable(applied[8]), .converterPowerOn(applied[9]),
    .gainStagePowerOn(applied[10]), .converterValue(applied[20:11]),
    .externalChannelBypass(applied[21]), .gainTenEnable(applied[22]),
    .gainTwentyEnable(applied[23]), .switchCapClock(applied[24]));
  bscac_link_checker #(.HALF_CYCLES(8)) i_bscac_link_checker (.ref_clk(ref_clk), .rst_n(rst_n),
    .tck(link.tck), .tdi(link.tdi), .tdo(link.tdo), .captureDr(link.captureDr),
    .shiftDr(link.shiftDr), .updateDr(link.updateDr), .extestMode(link.extestMode));
  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Wire order: first bit on the line lands in chain bit 0
  always @(posedge link.tck) begin
    if (link.shiftDr) begin
      tdiMon <= {link.tdi, tdiMon[29:1]};
      tdoMon <= {link.tdo, tdoMon[29:1]};
    end
  end
  // ----------------------------------------------------------------
  // Tasks
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge ref_clk);
    penable <= 1'b1;
    do @(posedge ref_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic frame(input logic ext);
    apb(1'b1, ADDR_CTRL, {30'h0, ext, 1'b1});
    do apb(1'b0, ADDR_STATUS, 32'h0); while (rd[ST_DONE] !== 1'b1);
    apb(1'b1, ADDR_STATUS, 32'h2);
  endtask : frame
  // Outputs lag the update by the link filter, so allow a bounded wait
  task automatic settle(input logic [NCTRL-1:0] exp);
    for (int i = 0; i < 20 && applied !== exp; i++) @(posedge ref_clk);
    check({7'h0, applied}, {7'h0, exp});
  endtask : settle
  task automatic give_verdict();
    $display("Checks %0d, miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict
  initial begin
    repeat (30000) @(posedge ref_clk);
    miscompares++;
    give_verdict();
  end
  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    {rst_n, psel, penable, pwrite, paddr, pwdata, lines, raw} = '0;
    funcCtrl = CTRL_SAFE;
    repeat (5) @(posedge ref_clk);
    check({7'h0, applied}, {7'h0, CTRL_SAFE});
    check({31'h0, cres}, 32'h0);
    rst_n <= 1'b1;
    apb(1'b0, ADDR_TX, 32'h0);
    check(rd, {7'h0, TX_RESET});
    $display("Reset test done");
    foreach (rows[r]) begin
      @(posedge ref_clk);
      lines <= rows[r].lines;
      raw <= rows[r].raw;
      apb(1'b1, ADDR_TX, {2'h0, rows[r].tx});
      frame(1'b1);
      frame(1'b1);
      for (int i = 0; i < NCLK; i++) expObs[i] = rows[r].tx[i] ? rows[r].lines[i] : CLK_UNUSED[i];
      apb(1'b0, ADDR_RX, 32'h0);
      check({27'h0, rd[OBS_RESULT:OBS_CLK_LSB]}, {27'h0, rows[r].raw, expObs});
      check({2'h0, tdiMon}, {2'h0, rows[r].tx});
      check({2'h0, tdoMon}, rd);
      settle(rows[r].tx[NCTRL-1:0]);
      check({31'h0, cres}, {31'h0, rows[r].tx[29]});
      $display("Row %0d done", r);
    end
    apb(1'b1, ADDR_CTRL, 32'h0);
    funcCtrl <= 25'h1234567;
    settle(25'h1234567);
    apb(1'b1, ADDR_TX, 32'h0aaaaa4);
    frame(1'b0);
    check({7'h0, applied}, 32'h1234567);
    apb(1'b1, ADDR_CTRL, 32'h2);
    settle(25'h0aaaaa4);
    $display("Sample mode test done");
    apb(1'b1, ADDR_TX, 32'h3);
    apb(1'b1, ADDR_CTRL, 32'h3);
    apb(1'b0, ADDR_STATUS, 32'h0);
    check({29'h0, rd[2:0]}, 32'h4);
    check({7'h0, applied}, 32'h0aaaaa4);
    apb(1'b0, 12'h010, 32'h0);
    check({rd[30:0], err}, 32'h1);
    $display("Refusal test done");
    @(posedge ref_clk);
    rst_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    check({7'h0, applied}, {7'h0, CTRL_SAFE});
    rst_n <= 1'b1;
    settle(25'h1234567);
    $display("Second reset test done");
    give_verdict();
  end
endmodule : tb_top
`default_nettype wire
